// ==== common/control_mode_pkg.sv ====
// constants, register layout and carrier types for the control mode selector
// assumes four-level strap pins arrive as 2-bit level codes from comparators
package control_mode_pkg;
   // ----------------------------------------------------------------------
   // serial word layout
   // ----------------------------------------------------------------------
   localparam int          WORD_BITS      = 16;
   localparam int          ADDR_BITS      = 5;
   localparam int          DATA_BITS      = 11;
   localparam int          REG_COUNT      = 32;
   localparam logic [4:0]  BIT_CNT_LAST   = 5'h0f;
   localparam logic [4:0]  BIT_CNT_ZERO   = 5'h00;
   localparam logic [4:0]  SOFT_RST_ADDR  = 5'h00;
   localparam int          SOFT_RST_BIT   = 4;
   localparam logic [10:0] REG_DEFAULT    = 11'h000;
   // serial mode configuration register and its fields
   localparam logic [4:0]  CFG_ADDR       = 5'h01;
   localparam int          CFG_SBIN_BIT   = 0;
   localparam int          CFG_CMOS_BIT   = 1;
   localparam int          CFG_EXTREF_BIT = 2;
   localparam int          CFG_GAIN_BIT   = 3;
   localparam int          CFG_STBY_BIT   = 4;
   localparam int          CFG_BUFOFF_BIT = 5;
   localparam int          CFG_GPD_BIT    = 6;
   // ----------------------------------------------------------------------
   // strap level codes: 0, 3/8, 5/8, full supply
   // ----------------------------------------------------------------------
   localparam logic [1:0]  LVL_GND        = 2'h0;
   localparam logic [1:0]  LVL_3_8        = 2'h1;
   localparam logic [1:0]  LVL_5_8        = 2'h2;
   localparam logic [1:0]  LVL_FULL       = 2'h3;
   localparam int          LVL_HI_BIT     = 1;
   // ----------------------------------------------------------------------
   // apb map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  APB_STATUS     = 8'h00;
   localparam logic [7:0]  APB_RD_INDEX   = 8'h04;
   localparam logic [7:0]  APB_RD_DATA    = 8'h08;
   localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;
   localparam int          SYNC_BITS      = 7;
   // ----------------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic global_power_down;
      logic buffers_off;
      logic standby;
      logic coarse_gain;
      logic external_reference;
      logic cmos_interface;
      logic straight_binary;
   } cfg_type;
   typedef struct packed {
      logic       reset_pin;
      logic [1:0] select_lvl;
      logic [1:0] clock_lvl;
      logic       data_pin;
      logic       power_down;
   } pins_type;
endpackage

// ==== design/control_mode_select.sv ====
// control mode selector: reset pin level picks serial or parallel control
// assumes strap comparators upstream and an apb master on clk_sys
`timescale 1ns/10ps
`default_nettype none
module control_mode_select
   import control_mode_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // shared device pins
   input  wire logic        reset_pin,
   input  wire logic [1:0]  serial_select_pin,
   input  wire logic [1:0]  serial_clock_pin,
   input  wire logic        serial_data_pin,
   input  wire logic        power_down_pin,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // applied configuration
   output cfg_type          cfg_out,
   output logic             serial_mode
);
   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   pins_type              pins_raw;
   logic [SYNC_BITS-1:0]  sync1_r;
   logic [SYNC_BITS-1:0]  sync2_r;
   pins_type              pins_s;
   assign pins_raw = '{reset_pin, serial_select_pin, serial_clock_pin,
                       serial_data_pin, power_down_pin};
   assign pins_s   = pins_type'(sync2_r);
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_BITS; gi++) begin : g_sync
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pins_raw[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate
   // ----------------------------------------------------------------------
   // serial shifter
   // ----------------------------------------------------------------------
   logic                   sclk_d_r;
   logic [4:0]             bit_cnt_r;
   logic [4:0]             bit_cnt_nxt;
   logic [WORD_BITS-1:0]   shift_r;
   logic [WORD_BITS-1:0]   shift_nxt;
   logic [DATA_BITS-1:0]   regs_r [REG_COUNT];
   logic                   soft_rst_r;
   logic                   sen_low;
   logic                   sclk_fall;
   logic                   word_done;
   logic                   hw_defaults;
   logic [ADDR_BITS-1:0]   word_addr;
   logic [DATA_BITS-1:0]   word_data;
   logic                   serial_now;
   assign serial_now  = ~pins_s.reset_pin;
   assign sen_low     = serial_now & ~pins_s.select_lvl[LVL_HI_BIT];
   assign sclk_fall   = sclk_d_r & ~pins_s.clock_lvl[LVL_HI_BIT];
   assign shift_nxt   = {shift_r[WORD_BITS-2:0], pins_s.data_pin};
   assign word_done   = sen_low & sclk_fall & (bit_cnt_r == BIT_CNT_LAST);
   // counter restarts when select rises, so a partial word is dropped
   assign bit_cnt_nxt = !sen_low ? BIT_CNT_ZERO :
                        !sclk_fall ? bit_cnt_r :
                        word_done ? BIT_CNT_ZERO : bit_cnt_r + 5'h01;
   assign word_addr   = shift_nxt[WORD_BITS-1 -: ADDR_BITS];
   assign word_data   = shift_nxt[DATA_BITS-1:0];
   // reset pin high also covers parallel mode, holding defaults throughout
   assign hw_defaults = pins_s.reset_pin;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d_r  <= 1'b0;
         bit_cnt_r <= BIT_CNT_ZERO;
         shift_r   <= '0;
      end else begin
         sclk_d_r  <= pins_s.clock_lvl[LVL_HI_BIT];
         bit_cnt_r <= bit_cnt_nxt;
         if (sen_low && sclk_fall) begin
            shift_r <= shift_nxt;
         end
      end
   end
   // ----------------------------------------------------------------------
   // register array
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         soft_rst_r <= 1'b0;
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_r[i] <= REG_DEFAULT;
         end
      end else if (hw_defaults || soft_rst_r) begin
         // defaults are all zero, so the soft bit clears itself here
         soft_rst_r <= 1'b0;
         for (int i = 0; i < REG_COUNT; i++) begin
            regs_r[i] <= REG_DEFAULT;
         end
      end else if (word_done) begin
         regs_r[word_addr] <= word_data;
         soft_rst_r <= (word_addr == SOFT_RST_ADDR) & word_data[SOFT_RST_BIT];
      end
   end
   // ----------------------------------------------------------------------
   // configuration select
   // ----------------------------------------------------------------------
   cfg_type              par_cfg;
   cfg_type              ser_cfg;
   logic [DATA_BITS-1:0] cfg_word;
   assign cfg_word = regs_r[CFG_ADDR];
   // select strap: coding and interface
   assign par_cfg.straight_binary    = (pins_s.select_lvl == LVL_3_8) |
                                       (pins_s.select_lvl == LVL_5_8);
   assign par_cfg.cmos_interface     = (pins_s.select_lvl == LVL_5_8) |
                                       (pins_s.select_lvl == LVL_FULL);
   // clock strap: reference and coarse gain
   assign par_cfg.external_reference = (pins_s.clock_lvl == LVL_3_8) |
                                       (pins_s.clock_lvl == LVL_5_8);
   assign par_cfg.coarse_gain        = (pins_s.clock_lvl == LVL_5_8) |
                                       (pins_s.clock_lvl == LVL_FULL);
   // data and power-down straps
   assign par_cfg.standby            = ~pins_s.data_pin & pins_s.power_down;
   assign par_cfg.buffers_off        = pins_s.data_pin & ~pins_s.power_down;
   assign par_cfg.global_power_down  = pins_s.data_pin & pins_s.power_down;
   assign ser_cfg.straight_binary    = cfg_word[CFG_SBIN_BIT];
   assign ser_cfg.cmos_interface     = cfg_word[CFG_CMOS_BIT];
   assign ser_cfg.external_reference = cfg_word[CFG_EXTREF_BIT];
   assign ser_cfg.coarse_gain        = cfg_word[CFG_GAIN_BIT];
   assign ser_cfg.standby            = cfg_word[CFG_STBY_BIT];
   assign ser_cfg.buffers_off        = cfg_word[CFG_BUFOFF_BIT];
   assign ser_cfg.global_power_down  = cfg_word[CFG_GPD_BIT];
   // straps act from the first synced sample, no reset pulse needed
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_out     <= '0;
         serial_mode <= 1'b0;
      end else begin
         cfg_out     <= serial_now ? ser_cfg : par_cfg;
         serial_mode <= serial_now;
      end
   end
   // ----------------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------------
   logic [ADDR_BITS-1:0] rd_index_r;
   logic                 apb_go;
   logic                 apb_done;
   logic                 hit_status;
   logic                 hit_index;
   logic                 hit_data;
   logic                 unmapped;
   logic [31:0]          rd_mux;
   assign apb_go     = psel & penable & ~pready;
   // writes land only at the completing edge, when the master sees pready
   assign apb_done   = psel & penable & pready;
   assign hit_status = (paddr == APB_STATUS);
   assign hit_index  = (paddr == APB_RD_INDEX);
   assign hit_data   = (paddr == APB_RD_DATA);
   // status and data words are read only; writing them is an error
   assign unmapped   = ~(hit_index | (~pwrite & (hit_status | hit_data)));
   assign rd_mux     = hit_status ? {23'h00_0000, soft_rst_r, serial_mode, cfg_out} :
                       hit_index  ? {27'h000_0000, rd_index_r} :
                       hit_data   ? {21'h00_0000, regs_r[rd_index_r]} : ZERO_WORD;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready     <= 1'b0;
         pslverr    <= 1'b0;
         prdata     <= ZERO_WORD;
         rd_index_r <= '0;
      end else begin
         pready  <= apb_go;
         pslverr <= apb_go & unmapped;
         prdata  <= (apb_go && !pwrite && !unmapped) ? rd_mux : ZERO_WORD;
         if (apb_done && pwrite && hit_index) begin
            rd_index_r <= pwdata[ADDR_BITS-1:0];
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/control_mode_select_tb.sv ====
// self-checking bench for control_mode_select
// apb driven here, pins through host_pins
`timescale 1ns/10ps
`default_nettype none
module control_mode_select_tb
   import control_mode_pkg::*;
;
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s exp %h got %h", nm, e, g); end end
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, serial_mode;
   cfg_type     cfg_out;
   pins_type    pins;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cycles = 0;
   always #50 clk_sys = ~clk_sys;
   host_pins u_host_pins (.clk_sys(clk_sys), .pins(pins));
   control_mode_select u_control_mode_select (.clk_sys(clk_sys), .rst_n(rst_n),
      .reset_pin(pins.reset_pin), .serial_select_pin(pins.select_lvl),
      .serial_clock_pin(pins.clock_lvl), .serial_data_pin(pins.data_pin),
      .power_down_pin(pins.power_down), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cfg_out(cfg_out), .serial_mode(serial_mode));
   // idle cycle after each transfer keeps psel from being set twice in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic word(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) u_host_pins.put(w[i]);
   endtask
   task automatic t_parallel();
      cfg_type e;
      for (int i = 0; i < 16; i++) begin
         u_host_pins.strap(i[1:0], i[3:2], i[1], i[3]);
         repeat (5) @(posedge clk_sys);
         e = '{i[3] & i[1], i[1] & !i[3], !i[1] & i[3], i[3], i[3] ^ i[2], i[1], i[1] ^ i[0]};
         `CHK("cfg", e, cfg_out)
      end
      apb(1'b0, APB_STATUS, ZERO_WORD);
      `CHK("status", {25'h000_0000, e}, rd)
   endtask
   task automatic t_serial();
      u_host_pins.serial_on();
      u_host_pins.sel(1'b1);
      word({CFG_ADDR, 11'h05a});
      word({5'h02, 11'h7ff});
      for (int i = 0; i < 3; i++) u_host_pins.put(1'b1);
      u_host_pins.sel(1'b0);
      `CHK("cfg", 7'h5a, cfg_out)
      apb(1'b1, APB_RD_INDEX, 32'h0000_0002);
      apb(1'b0, APB_RD_DATA, ZERO_WORD);
      `CHK("reg2", 32'h0000_07ff, rd)
      apb(1'b0, APB_STATUS, ZERO_WORD);
      `CHK("status", 32'h0000_00da, rd)
      apb(1'b1, APB_RD_DATA, 32'hffff_ffff);
      `CHK("ro_err", 1'b1, err)
      apb(1'b0, 8'h0c, ZERO_WORD);
      `CHK("map_err", 1'b1, err)
   endtask
   task automatic t_soft();
      u_host_pins.sel(1'b1);
      word({SOFT_RST_ADDR, 11'h010});
      u_host_pins.sel(1'b0);
      `CHK("cfg", 7'h00, cfg_out)
      apb(1'b0, APB_RD_DATA, ZERO_WORD);
      `CHK("reg2", ZERO_WORD, rd)
      apb(1'b0, APB_STATUS, ZERO_WORD);
      `CHK("status", 32'h0000_0080, rd)
      apb(1'b1, APB_RD_INDEX, ZERO_WORD);
      apb(1'b0, APB_RD_DATA, ZERO_WORD);
      `CHK("reg0", ZERO_WORD, rd)
   endtask
   task automatic t_pulse();
      u_host_pins.sel(1'b1);
      word({CFG_ADDR, 11'h07f});
      u_host_pins.sel(1'b0);
      `CHK("cfg", 7'h7f, cfg_out)
      u_host_pins.serial_on();
      `CHK("cfg", 7'h00, cfg_out)
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      psel    <= 1'b0;
      penable <= 1'b0;
      pwrite  <= 1'b0;
      paddr   <= 8'h00;
      pwdata  <= ZERO_WORD;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_parallel();
      t_serial();
      t_soft();
      t_pulse();
      end_of_test();
   end
endmodule
`default_nettype wire

// ==== dv/host_pins.sv ====
// host side of the shared pins: strapping or serial register writes
// bench calls the tasks right after a clk_sys edge
`timescale 1ns/10ps
`default_nettype none
module host_pins
   import control_mode_pkg::*;
(
   input  wire logic     clk_sys,
   output var pins_type  pins
);
   initial pins = '{1'b1, LVL_FULL, LVL_FULL, 1'b0, 1'b0};
   // host paces its pin changes on clk_sys, the same clock that the design samples the pins with
   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic strap(input logic [1:0] s, input logic [1:0] c, input logic d, input logic p);
      pins <= '{1'b1, s, c, d, p};
   endtask
   // pulse restores defaults, then the pin stays low
   task automatic serial_on();
      pins.reset_pin <= 1'b1;
      hold(4);
      pins.reset_pin <= 1'b0;
      hold(6);
   endtask
   // undriven data line must not keep its last value
   task automatic sel(input logic act);
      pins.select_lvl <= act ? LVL_GND : LVL_FULL;
      pins.data_pin   <= ~pins.data_pin;
      hold(4);
   endtask
   // phases of 4 clocks leave room for the 2-stage sync
   task automatic put(input logic b);
      pins.data_pin <= b;
      hold(4);
      pins.clock_lvl <= LVL_GND;
      hold(4);
      pins.clock_lvl <= LVL_FULL;
      hold(4);
   endtask
endmodule
`default_nettype wire

// ==== dv/mode_checker.sv ====
// assertions on mode choice and strap decoding of control_mode_select
// bound to the design, one clock domain
`timescale 1ns/10ps
`default_nettype none
module mode_checker
   import control_mode_pkg::*;
(
   // clock and reset
   input wire logic       clk_sys,
   input wire logic       rst_n,
   // shared pins
   input wire logic       reset_pin,
   input wire logic [1:0] serial_select_pin,
   input wire logic [1:0] serial_clock_pin,
   input wire logic       serial_data_pin,
   input wire logic       power_down_pin,
   // applied configuration
   input wire cfg_type    cfg_out,
   input wire logic       serial_mode
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // strap must stay put through the sync chain before decode is judged
   sequence sel_held(logic [1:0] v);
      (reset_pin && serial_select_pin == v)[*4];
   endsequence
   mode_par_a: assert property ($rose(reset_pin) |-> ##3 !serial_mode)
      else $error("parallel mode late");
   mode_ser_a: assert property ($fell(reset_pin) |-> ##3 serial_mode)
      else $error("serial mode late");
   lvds_twos_a: assert property (sel_held(LVL_GND) |->
      !cfg_out.straight_binary && !cfg_out.cmos_interface) else $error("gnd select");
   sb_cmos_a: assert property (sel_held(LVL_5_8) |->
      cfg_out.straight_binary && cfg_out.cmos_interface) else $error("5/8 select");
   ext_ref_a: assert property ((reset_pin && serial_clock_pin == LVL_3_8)[*4] |->
      cfg_out.external_reference && !cfg_out.coarse_gain) else $error("3/8 clock");
   standby_only_a: assert property ((reset_pin && !serial_data_pin && power_down_pin)[*4] |->
      cfg_out.standby && !cfg_out.global_power_down) else $error("standby");
   global_pd_a: assert property ((reset_pin && serial_data_pin && power_down_pin)[*4] |->
      cfg_out.global_power_down && !cfg_out.standby) else $error("global pd");
   strap_hold_a: assert property ((rst_n && $stable({reset_pin, serial_select_pin,
      serial_clock_pin, serial_data_pin, power_down_pin}) && reset_pin)[*5]
      |-> $stable(cfg_out)) else $error("cfg moved");
endmodule
bind control_mode_select mode_checker u_mode_checker (.clk_sys, .rst_n, .reset_pin,
   .serial_select_pin, .serial_clock_pin, .serial_data_pin, .power_down_pin, .cfg_out,
   .serial_mode);
`default_nettype wire
